// File: src/slcr_pkg.sv
// Purpose: Constants, register map and carrier types for the lane configuration registers
// Assumes: 10 MHz core clock; MDC well below a quarter of it
// Notes: Register addresses are the management register numbers within devices 4 and 5
package slcr_pkg;
    localparam int REG_N = 9;
    localparam int IDX_RXPH = 0, IDX_SYNC = 1, IDX_CFG1 = 2, IDX_CFG2 = 3, IDX_PAIR = 4;
    localparam int IDX_PLL = 5, IDX_STAT = 6, IDX_TFAIL = 7, IDX_TEST = 8;
    localparam logic [REG_N-1:0][15:0] REG_ADDR = {16'h808a, 16'h8089, 16'h8088, 16'h8087,
        16'h8086, 16'h8085, 16'h8084, 16'h8027, 16'h8026};
    localparam logic [REG_N-1:0][15:0] REG_RESET = {16'h0000, 16'h8000, 16'h0000, 16'h8000,
        16'hffff, 16'h0ac0, 16'h806c, 16'h0000, 16'h0000};
    localparam logic [REG_N-1:0][15:0] REG_WMASK = {16'h3fff, 16'h8000, 16'h0000, 16'h8000,
        16'hffff, 16'hffc0, 16'hffff, 16'hff00, 16'hf800};
    // Management frame constants
    localparam logic [4:0] DEVAD_A = 5'h04;
    localparam logic [4:0] DEVAD_B = 5'h05;
    localparam logic [1:0] OP_ADDR = 2'h0, OP_WRITE = 2'h1, OP_RINC = 2'h2, OP_READ = 2'h3;
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [5:0] HDR_LAST = 6'h0c;
    localparam logic [5:0] DATA_LAST = 6'h0f;
    localparam logic [7:0] PAIR_ALL_ON = 8'hff;
    // Field positions
    localparam int POS_PHASE = 12, POS_SRC_TIMING = 11, POS_BYPASS = 12, POS_FREEZE = 8;
    localparam int POS_SHCLK = 15, POS_PREEMPH = 11, POS_SWING = 9, POS_SLEW = 7;
    localparam int POS_EXTERNAL_AMPLITUDE_REF = 6, POS_ACCPL = 5, POS_LOL = 4, POS_EQHI = 3, POS_EQON = 2;
    localparam int POS_QUPD = 1, POS_QLOCK = 0, POS_JNC = 15, POS_RATE = 13, POS_BYTE = 12;
    localparam int POS_LBW = 11, POS_MUL = 8, POS_TXTEST = 7, POS_RXTEST = 6;
    localparam int POS_TXEN = 8, POS_RXEN = 0, POS_PLLEN = 15, POS_TFSEL = 15;
    localparam int POS_EQTEST = 12, POS_PADLP = 11, POS_LOOP = 10, POS_SCAN_INPUT_ENABLE = 9;
    localparam int POS_SCAN_OUTPUT_ENABLE = 8, POS_RAMP = 4, POS_PLLBYP = 3, POS_PATT = 0;
    localparam logic [1:0] SWING_NO_EMPH = 2'h2;
    localparam logic [2:0] PATT_LAST_LEGAL = 3'h4;

    typedef enum logic [1:0] {PH_PRE, PH_HDR, PH_TA, PH_DATA} slcr_phase_t;
    typedef logic [3:0][9:0] slcr_lanes_t;
    typedef logic [REG_N-1:0][15:0] slcr_regs_t;

    typedef struct packed {
        logic [3:0] lane_phase_shift;
        logic rx_src_aligned;
        logic [3:0] sync_bypass;
        logic [3:0] sync_freeze;
        logic shared_tx_clock_select;
        logic [3:0] pre_emphasis;
        logic [1:0] swing;
        logic [1:0] slew;
        logic external_amplitude_ref;
        logic ac_coupled;
        logic link_loss_detect_on;
        logic equalizer_high_rate;
        logic equalizer_on;
        logic quick_update_mode;
        logic quick_lock_mode;
        logic jog_or_comma_select;
        logic [1:0] line_rate_select;
        logic byte_width_mode;
        logic pll_low_bandwidth;
        logic [2:0] pll_multiplier;
        logic tx_test_features_on;
        logic rx_test_features_on;
        logic pll_enable;
        logic [1:0] equalizer_test_mode;
        logic loopback_enable;
        logic pad_loop_enable;
        logic scan_input_enable_rx;
        logic scan_output_enable_tx;
        logic [3:0] freq_ramp_mode;
        logic pll_bypass;
        logic [2:0] pattern_gen_select;
        logic [2:0] pattern_check_select;
    } slcr_ctrl_t;

    typedef struct packed {
        logic mdc_s1, mdc_s2, mdc_s3;
        logic mdio_s1, mdio_s2;
        logic [4:0] prtad_s1, prtad_s2;
        slcr_phase_t phase;
        logic [5:0] cnt;
        logic [15:0] shift;
        logic [1:0] op;
        logic hit;
        logic [15:0] addr;
        logic [15:0] rd_data;
        logic mdio_o, mdio_oe;
        slcr_regs_t regs;
        slcr_ctrl_t ctrl;
        logic [7:0] tx_pair_en, rx_pair_en;
        logic testfail;
        slcr_lanes_t rx_d1, rx_out;
    } slcr_state_t;
endpackage

// File: src/slcr_regs.sv
// Purpose: Clause 45 management slave holding the lane and serializer configuration registers
// Assumes: MDC at most 2.5 MHz so each MDC level lasts two core clocks or more
// Notes: Read data changes about three core clocks after the MDC rising edge
`timescale 1ns/100ps
`default_nettype none

module slcr_regs (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Management pins
    input wire logic I_MDC,
    input wire logic I_MDIO,
    output logic O_MDIO_O,
    output logic O_MDIO_OE,
    input wire logic [4:0] I_PRTAD,
    // Power-down and test-fail sources
    input wire logic I_PWRDN_ALL,
    input wire logic I_PWRDN_A,
    input wire logic I_PWRDN_B,
    input wire logic I_TX_TESTFAIL,
    input wire logic I_RX_TESTFAIL,
    // Receive lane data
    input wire slcr_pkg::slcr_lanes_t I_RX_LANE_DATA,
    output var slcr_pkg::slcr_lanes_t O_RX_LANE_DATA,
    // Configuration outputs
    output var slcr_pkg::slcr_ctrl_t O_CTRL,
    output logic [7:0] O_TX_PAIR_EN,
    output logic [7:0] O_RX_PAIR_EN,
    output logic O_TESTFAIL
);

    slcr_pkg::slcr_state_t s_q;
    slcr_pkg::slcr_state_t s_d;
    logic mdc_rise;
    logic wr_fire;
    logic [3:0] wr_idx;

    // Maps an address to a register index; REG_N when unmapped
    function automatic logic [3:0] reg_index(input logic [15:0] a);
        logic [3:0] r;
        r = 4'(slcr_pkg::REG_N);
        for (int i = 0; i < slcr_pkg::REG_N; i++) begin
            if (slcr_pkg::REG_ADDR[i] == a) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] reg_read(input slcr_pkg::slcr_regs_t r, input logic [15:0] a);
        logic [3:0] i;
        i = reg_index(a);
        if (i == 4'(slcr_pkg::REG_N)) begin
            return 16'h0000;
        end
        return r[i] & slcr_pkg::REG_WMASK[i];
    endfunction

    // Derives the configuration outputs from the register contents
    function automatic slcr_pkg::slcr_ctrl_t build_ctrl(input slcr_pkg::slcr_regs_t r);
        slcr_pkg::slcr_ctrl_t c;
        logic [15:0] ph, sy, c1, c2, tc;
        ph = r[slcr_pkg::IDX_RXPH];
        sy = r[slcr_pkg::IDX_SYNC];
        c1 = r[slcr_pkg::IDX_CFG1];
        c2 = r[slcr_pkg::IDX_CFG2];
        tc = r[slcr_pkg::IDX_TEST];
        c = '0;
        c.lane_phase_shift = ph[slcr_pkg::POS_PHASE +: 4];
        c.rx_src_aligned = ph[slcr_pkg::POS_SRC_TIMING];
        c.sync_bypass = sy[slcr_pkg::POS_BYPASS +: 4];
        c.sync_freeze = sy[slcr_pkg::POS_FREEZE +: 4];
        c.shared_tx_clock_select = c1[slcr_pkg::POS_SHCLK];
        c.swing = c1[slcr_pkg::POS_SWING +: 2];
        // Pre-emphasis is unavailable at the 37.5% amplitude setting
        if (c.swing == slcr_pkg::SWING_NO_EMPH) begin
            c.pre_emphasis = 4'h0;
        end else begin
            c.pre_emphasis = c1[slcr_pkg::POS_PREEMPH +: 4];
        end
        c.slew = c1[slcr_pkg::POS_SLEW +: 2];
        c.external_amplitude_ref = c1[slcr_pkg::POS_EXTERNAL_AMPLITUDE_REF];
        c.ac_coupled = c1[slcr_pkg::POS_ACCPL];
        c.link_loss_detect_on = c1[slcr_pkg::POS_LOL];
        c.equalizer_high_rate = c1[slcr_pkg::POS_EQHI];
        c.equalizer_on = c1[slcr_pkg::POS_EQON];
        c.quick_update_mode = c1[slcr_pkg::POS_QUPD];
        c.quick_lock_mode = c1[slcr_pkg::POS_QLOCK];
        c.jog_or_comma_select = c2[slcr_pkg::POS_JNC];
        c.line_rate_select = c2[slcr_pkg::POS_RATE +: 2];
        c.byte_width_mode = c2[slcr_pkg::POS_BYTE];
        c.pll_low_bandwidth = c2[slcr_pkg::POS_LBW];
        c.pll_multiplier = c2[slcr_pkg::POS_MUL +: 3];
        c.tx_test_features_on = c2[slcr_pkg::POS_TXTEST];
        c.rx_test_features_on = c2[slcr_pkg::POS_RXTEST];
        c.pll_enable = r[slcr_pkg::IDX_PLL][slcr_pkg::POS_PLLEN];
        c.equalizer_test_mode = tc[slcr_pkg::POS_EQTEST +: 2];
        c.loopback_enable = tc[slcr_pkg::POS_LOOP];
        c.pad_loop_enable = tc[slcr_pkg::POS_PADLP] & tc[slcr_pkg::POS_LOOP];
        c.scan_input_enable_rx = tc[slcr_pkg::POS_SCAN_INPUT_ENABLE];
        c.scan_output_enable_tx = tc[slcr_pkg::POS_SCAN_OUTPUT_ENABLE];
        c.freq_ramp_mode = tc[slcr_pkg::POS_RAMP +: 4];
        c.pll_bypass = tc[slcr_pkg::POS_PLLBYP];
        // Reserved pattern codes act as disabled
        if (tc[slcr_pkg::POS_PATT +: 3] <= slcr_pkg::PATT_LAST_LEGAL) begin
            c.pattern_gen_select = tc[slcr_pkg::POS_PATT +: 3];
        end
        c.pattern_check_select = c.pattern_gen_select;
        return c;
    endfunction

    assign mdc_rise = s_q.mdc_s2 & ~s_q.mdc_s3;
    assign wr_idx = reg_index(s_q.addr);
    assign wr_fire = mdc_rise && s_q.phase == slcr_pkg::PH_DATA && s_q.cnt == slcr_pkg::DATA_LAST
        && s_q.hit && s_q.op == slcr_pkg::OP_WRITE;

    always_comb begin
        logic [15:0] word;
        logic [4:0] dev;
        logic [1:0] op;
        logic [7:0] tx_en, rx_en;
        word = {s_q.shift[14:0], s_q.mdio_s2};
        dev = word[4:0];
        op = word[11:10];
        tx_en = s_q.regs[slcr_pkg::IDX_PAIR][slcr_pkg::POS_TXEN +: 8];
        rx_en = s_q.regs[slcr_pkg::IDX_PAIR][slcr_pkg::POS_RXEN +: 8];
        s_d = s_q;
        // Two-stage synchronisers on the pins
        s_d.mdc_s1 = I_MDC;
        s_d.mdc_s2 = s_q.mdc_s1;
        s_d.mdc_s3 = s_q.mdc_s2;
        s_d.mdio_s1 = I_MDIO;
        s_d.mdio_s2 = s_q.mdio_s1;
        s_d.prtad_s1 = I_PRTAD;
        s_d.prtad_s2 = s_q.prtad_s1;
        if (mdc_rise) begin
            unique case (s_q.phase)
                slcr_pkg::PH_PRE: begin
                    if (s_q.mdio_s2) begin
                        if (s_q.cnt != slcr_pkg::PREAMBLE_LEN) begin
                            s_d.cnt = s_q.cnt + 6'h01;
                        end
                    end else if (s_q.cnt == slcr_pkg::PREAMBLE_LEN) begin
                        s_d.phase = slcr_pkg::PH_HDR;
                        s_d.cnt = '0;
                        s_d.shift = '0;
                    end else begin
                        s_d.cnt = '0;
                    end
                end
                slcr_pkg::PH_HDR: begin
                    s_d.shift = word;
                    s_d.cnt = s_q.cnt + 6'h01;
                    if (s_q.cnt == slcr_pkg::HDR_LAST) begin
                        s_d.phase = slcr_pkg::PH_TA;
                        s_d.cnt = '0;
                        s_d.op = op;
                        s_d.hit = !word[12] && word[9:5] == s_q.prtad_s2
                            && (dev == slcr_pkg::DEVAD_A || dev == slcr_pkg::DEVAD_B);
                        s_d.rd_data = reg_read(s_q.regs, s_q.addr);
                    end
                end
                slcr_pkg::PH_TA: begin
                    s_d.cnt = s_q.cnt + 6'h01;
                    if (s_q.hit && s_q.op[1]) begin
                        s_d.mdio_oe = 1'b1;
                        s_d.mdio_o = (s_q.cnt == 6'h00) ? 1'b0 : s_q.rd_data[15];
                        if (s_q.cnt != 6'h00) begin
                            s_d.rd_data = {s_q.rd_data[14:0], 1'b0};
                        end
                    end
                    if (s_q.cnt != 6'h00) begin
                        s_d.phase = slcr_pkg::PH_DATA;
                        s_d.cnt = '0;
                    end
                end
                slcr_pkg::PH_DATA: begin
                    s_d.shift = word;
                    s_d.cnt = s_q.cnt + 6'h01;
                    s_d.mdio_o = s_q.rd_data[15];
                    s_d.rd_data = {s_q.rd_data[14:0], 1'b0};
                    if (s_q.cnt == slcr_pkg::DATA_LAST) begin
                        s_d.phase = slcr_pkg::PH_PRE;
                        s_d.cnt = '0;
                        s_d.mdio_oe = 1'b0;
                        s_d.mdio_o = 1'b0;
                        if (s_q.hit) begin
                            unique case (s_q.op)
                                slcr_pkg::OP_ADDR: s_d.addr = word;
                                slcr_pkg::OP_RINC: s_d.addr = s_q.addr + 16'h0001;
                                slcr_pkg::OP_WRITE: begin
                                    if (wr_idx != 4'(slcr_pkg::REG_N)) begin
                                        s_d.regs[wr_idx] = (word & slcr_pkg::REG_WMASK[wr_idx])
                                            | (s_q.regs[wr_idx] & ~slcr_pkg::REG_WMASK[wr_idx]);
                                    end
                                end
                                slcr_pkg::OP_READ: s_d.addr = s_q.addr;
                            endcase
                        end
                    end
                end
            endcase
        end
        s_d.ctrl = build_ctrl(s_q.regs);
        // Power-down of the device or one side overrides the enables
        if (I_PWRDN_ALL || I_PWRDN_A) begin
            tx_en[3:0] = 4'h0;
            rx_en[3:0] = 4'h0;
        end
        if (I_PWRDN_ALL || I_PWRDN_B) begin
            tx_en[7:4] = 4'h0;
            rx_en[7:4] = 4'h0;
        end
        s_d.tx_pair_en = tx_en;
        s_d.rx_pair_en = rx_en;
        s_d.testfail = s_q.regs[slcr_pkg::IDX_TFAIL][slcr_pkg::POS_TFSEL]
            ? I_RX_TESTFAIL : I_TX_TESTFAIL;
        s_d.rx_d1 = I_RX_LANE_DATA;
        for (int l = 0; l < 4; l++) begin
            s_d.rx_out[l] = s_q.ctrl.lane_phase_shift[l] ? s_q.rx_d1[l] : I_RX_LANE_DATA[l];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            s_q <= '0;
            s_q.phase <= slcr_pkg::PH_PRE;
            s_q.regs <= slcr_pkg::REG_RESET;
            s_q.ctrl <= build_ctrl(slcr_pkg::REG_RESET);
            s_q.tx_pair_en <= slcr_pkg::PAIR_ALL_ON;
            s_q.rx_pair_en <= slcr_pkg::PAIR_ALL_ON;
        end else begin
            s_q <= s_d;
        end
    end

    assign O_MDIO_O = s_q.mdio_o;
    assign O_MDIO_OE = s_q.mdio_oe;
    assign O_RX_LANE_DATA = s_q.rx_out;
    assign O_CTRL = s_q.ctrl;
    assign O_TX_PAIR_EN = s_q.tx_pair_en;
    assign O_RX_PAIR_EN = s_q.rx_pair_en;
    assign O_TESTFAIL = s_q.testfail;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    sequence s_write_done;
        wr_fire;
    endsequence

    sequence s_swing_gated;
        s_q.regs[slcr_pkg::IDX_CFG1][slcr_pkg::POS_SWING +: 2] == slcr_pkg::SWING_NO_EMPH;
    endsequence

    generate
        for (genvar l = 0; l < 4; l++) begin : g_lane_chk
            chk_phase_delay: assert property (
                ($past(s_q.ctrl.lane_phase_shift[l]) ##1 s_q.ctrl.lane_phase_shift[l])
                |-> O_RX_LANE_DATA[l] == $past(I_RX_LANE_DATA[l], 2))
                else $error("phase-shifted lane not delayed by one cycle");
            chk_phase_direct: assert property (
                $past(I_RST_N) && !$past(s_q.ctrl.lane_phase_shift[l])
                |-> O_RX_LANE_DATA[l] == $past(I_RX_LANE_DATA[l]))
                else $error("unshifted lane data wrong");
        end
    endgenerate

    chk_reset_values: assert property ($past(!I_RST_N) |-> s_q.regs == slcr_pkg::REG_RESET
        && O_TX_PAIR_EN == 8'hff)
        else $error("register reset values wrong");

    chk_write_mask: assert property (s_write_done |=> s_q.regs[$past(wr_idx)]
        == (($past(s_q.shift[14:0]) << 1 | 16'($past(s_q.mdio_s2)))
        & slcr_pkg::REG_WMASK[$past(wr_idx)]
        | $past(s_q.regs[wr_idx]) & ~slcr_pkg::REG_WMASK[$past(wr_idx)]))
        else $error("masked register write wrong");

    chk_emph_gate: assert property (s_swing_gated |=> O_CTRL.pre_emphasis == 4'h0)
        else $error("pre-emphasis active at 37.5 percent swing");

    chk_pad_loop: assert property (O_CTRL.pad_loop_enable |-> O_CTRL.loopback_enable)
        else $error("pad loopback without internal loopback");

    chk_side_pwrdn: assert property ((I_PWRDN_A || I_PWRDN_ALL) |=> O_TX_PAIR_EN[3:0] == 4'h0
        && O_RX_PAIR_EN[3:0] == 4'h0)
        else $error("side A pairs enabled during power-down");

    chk_testfail_sel: assert property ($past(I_RST_N) |-> O_TESTFAIL == ($past(
        s_q.regs[slcr_pkg::IDX_TFAIL][slcr_pkg::POS_TFSEL]) ? $past(I_RX_TESTFAIL)
        : $past(I_TX_TESTFAIL)))
        else $error("test-fail routed from wrong source");

    chk_pattern_pair: assert property (O_CTRL.pattern_gen_select == O_CTRL.pattern_check_select
        && O_CTRL.pattern_gen_select <= slcr_pkg::PATT_LAST_LEGAL)
        else $error("pattern generator and checker disagree");

    chk_status_zero: assert property (s_q.phase == slcr_pkg::PH_HDR
        && reg_index(s_q.addr) == 4'(slcr_pkg::IDX_STAT) |=> s_q.phase != slcr_pkg::PH_TA
        || s_q.rd_data == 16'h0000)
        else $error("link status read not zero");

    chk_drive_read: assert property ($rose(O_MDIO_OE) |-> s_q.hit && s_q.op[1]
        && !O_MDIO_O)
        else $error("management pin driven outside a read");

endmodule

`default_nettype wire

// File: tb/slcr_regs_tb.sv
// Purpose: Self-checking bench for the lane configuration register block
// Assumes: Station model on the management pins, random lane and status traffic
// Notes: Checks pause while registers are being rewritten
`timescale 1ns/100ps
`default_nettype none

module slcr_regs_tb;
    localparam logic [8:0][15:0] ADR = {16'h808a, 16'h8089, 16'h8088, 16'h8087,
        16'h8086, 16'h8085, 16'h8084, 16'h8027, 16'h8026};
    localparam logic [8:0][15:0] RST = {16'h0000, 16'h8000, 16'h0000, 16'h8000,
        16'hffff, 16'h0ac0, 16'h806c, 16'h0000, 16'h0000};
    localparam logic [8:0][15:0] MSK = {16'h3fff, 16'h8000, 16'h0000, 16'h8000,
        16'hffff, 16'hffc0, 16'hffff, 16'hff00, 16'hf800};
    logic clk, rst_n, pw_all, pw_a, pw_b, tf_tx, tf_rx, tf_out, mdc, st_o, st_oe, d_o, d_oe;
    logic mon;
    logic [7:0] tx_en, rx_en, pm;
    logic [4:0] pv;
    logic [15:0] v, x;
    logic [8:0][15:0] mr;
    slcr_pkg::slcr_lanes_t lane_in, lane_out, h1, h2, el;
    slcr_pkg::slcr_ctrl_t ctrl;
    int bad_count, check_count;
    wire logic mdio_w = d_oe ? d_o : (st_oe ? st_o : 1'b1);

    slcr_regs slcr_regs_i (.I_CLK(clk), .I_RST_N(rst_n), .I_MDC(mdc), .I_MDIO(mdio_w),
        .O_MDIO_O(d_o), .O_MDIO_OE(d_oe), .I_PRTAD(5'h03), .I_PWRDN_ALL(pw_all),
        .I_PWRDN_A(pw_a), .I_PWRDN_B(pw_b), .I_TX_TESTFAIL(tf_tx), .I_RX_TESTFAIL(tf_rx),
        .I_RX_LANE_DATA(lane_in), .O_RX_LANE_DATA(lane_out), .O_CTRL(ctrl),
        .O_TX_PAIR_EN(tx_en), .O_RX_PAIR_EN(rx_en), .O_TESTFAIL(tf_out));
    slcr_station slcr_station_i (.o_mdc(mdc), .o_mdio(st_o), .o_mdio_oe(st_oe), .i_mdio(mdio_w));

    task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic mf(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] d);
        slcr_station_i.frame(op, dev, d, x);
    endtask

    task automatic rd_all(input logic [4:0] dev);
        for (int k = 0; k < 9; k++) begin
            if (k == 0 || k == 2) begin
                mf(slcr_pkg::OP_ADDR, dev, ADR[k]);
            end
            mf(slcr_pkg::OP_RINC, dev, 16'h0000);
            check("reg_read", 40'(x), 40'(mr[k]));
        end
    endtask

    task automatic chk_ctrl();
        logic [2:0] p;
        slcr_pkg::slcr_ctrl_t c;
        c = ctrl;
        p = (mr[8][2:0] > 3'h4) ? 3'h0 : mr[8][2:0];
        check("rx_timing", 40'({c.lane_phase_shift, c.rx_src_aligned}), 40'(mr[0][15:11]));
        check("word_sync", 40'({c.sync_bypass, c.sync_freeze}), 40'(mr[1][15:8]));
        check("cfg_one", 40'({c.shared_tx_clock_select, c.swing, c.slew, c.external_amplitude_ref,
            c.ac_coupled, c.link_loss_detect_on, c.equalizer_high_rate, c.equalizer_on,
            c.quick_update_mode, c.quick_lock_mode, c.pll_enable}),
            40'({mr[2][15], mr[2][10:0], mr[5][15]}));
        check("pre_emph", 40'(c.pre_emphasis),
            40'((mr[2][10:9] == 2'b10) ? 4'h0 : mr[2][14:11]));
        check("cfg_two", 40'({c.jog_or_comma_select, c.line_rate_select, c.byte_width_mode,
            c.pll_low_bandwidth, c.pll_multiplier, c.tx_test_features_on,
            c.rx_test_features_on}), 40'(mr[3][15:6]));
        check("test_cfg", 40'({c.equalizer_test_mode, c.loopback_enable, c.pad_loop_enable,
            c.scan_input_enable_rx, c.scan_output_enable_tx, c.freq_ramp_mode, c.pll_bypass}),
            40'({mr[8][13:12], mr[8][10], mr[8][11] & mr[8][10], mr[8][9:3]}));
        check("pattern", 40'({c.pattern_gen_select, c.pattern_check_select}), 40'({p, p}));
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Outputs checked against last cycle's inputs, phase-shifted lanes against the cycle before, then new random inputs
    always @(negedge clk) begin
        // Capture what the design took at the last rising edge before checking
        h2 = h1;
        h1 = lane_in;
        pv = {pw_all, pw_a, pw_b, tf_tx, tf_rx};
        if (mon) begin
            for (int l = 0; l < 4; l++) begin
                el[l] = mr[0][12 + l] ? h2[l] : h1[l];
            end
            pm = {{4{~(pv[4] | pv[2])}}, {4{~(pv[4] | pv[3])}}};
            check("lane_data", lane_out, el);
            check("tx_pairs", 40'(tx_en), 40'(mr[4][15:8] & pm));
            check("rx_pairs", 40'(rx_en), 40'(mr[4][7:0] & pm));
            check("test_fail", 40'(tf_out), 40'(mr[7][15] ? pv[0] : pv[1]));
        end
        lane_in = 40'({$urandom, $urandom});
        {pw_all, pw_a, pw_b} = 3'($urandom) & 3'($urandom) & 3'($urandom);
        {tf_tx, tf_rx} = 2'($urandom);
    end

    initial begin
        {rst_n, mon, pw_all, pw_a, pw_b, tf_tx, tf_rx} = 7'h00;
        {lane_in, h1, h2, pv} = '0;
        mr = RST;
        bad_count = 0;
        check_count = 0;
        v = 16'($urandom(46651));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd_all(5'h04);
        chk_ctrl();
        for (int r = 0; r < 8; r++) begin
            mon = 1'b0;
            for (int k = 0; k < 9; k++) begin
                v = 16'($urandom);
                if (k == 2) begin
                    v[10:9] = 2'(r);
                end
                if (k == 3) begin
                    v[10:8] = 3'(r);
                    v[14:13] = 2'(r);
                end
                if (k == 8) begin
                    v[2:0] = 3'(r);
                end
                mf(slcr_pkg::OP_ADDR, 5'h05, ADR[k]);
                mf(slcr_pkg::OP_WRITE, 5'h05, v);
                mr[k] = v & MSK[k];
            end
            repeat (10) @(negedge clk);
            mon = 1'b1;
            chk_ctrl();
            rd_all(5'h04);
        end
        mf(slcr_pkg::OP_ADDR, 5'h04, 16'h8030);
        mf(slcr_pkg::OP_READ, 5'h04, 16'h0000);
        check("unmapped", 40'(x), 40'h0);
        mf(slcr_pkg::OP_ADDR, 5'h06, ADR[7]);
        mf(slcr_pkg::OP_WRITE, 5'h06, ~mr[7]);
        mf(slcr_pkg::OP_READ, 5'h06, 16'h0000);
        check("foreign_dev", 40'(x), 40'hffff);
        mon = 1'b0;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        mr = RST;
        repeat (3) @(negedge clk);
        mon = 1'b1;
        rd_all(5'h05);
        chk_ctrl();
        final_report();
    end
endmodule

`default_nettype wire

// File: tb/slcr_station.sv
// Purpose: Clause 45 management station model for the register block
// Assumes: MDC period 500 ns, MDC stands low between frames
// Notes: A released wire reads as its pull-up level
`timescale 1ns/100ps
`default_nettype none

module slcr_station #(
    parameter logic [4:0] PRTAD = 5'h03
) (
    // Management pins
    output logic o_mdc,
    output logic o_mdio,
    output logic o_mdio_oe,
    input wire logic i_mdio
);
    initial begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_mdio_oe = 1'b0;
    end

    // One MDC period: drive b when own is set, and always sample the wire at the rise
    task automatic bit_cycle(input logic own, input logic b, output logic s);
        o_mdio_oe = own;
        o_mdio = b;
        #250 o_mdc = 1'b1;
        s = i_mdio;
        #250 o_mdc = 1'b0;
    endtask

    // Whole frame with its own preamble, MSB first; reads release TA and data
    task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] wd,
            output logic [15:0] rd);
        logic [63:0] v;
        logic s;
        v = {32'hffff_ffff, 2'b00, op, PRTAD, dev, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            bit_cycle(!(op[1] && i < 18), v[i], s);
            if (i < 16) begin
                rd = {rd[14:0], s};
            end
        end
        o_mdio_oe = 1'b0;
    endtask
endmodule

`default_nettype wire
